/* File: core/txcfg_pkg.sv */
// Constants for the transmit port configuration bank
package txcfg_pkg;
   localparam int unsigned NUM_PORTS = 16;
   localparam logic [15:0] PORT_STRIDE = 16'h0200;
   localparam logic [15:0] HALF_STRIDE = 16'h2000;
   localparam int unsigned PORTS_PER_HALF = 8;
   localparam logic [15:0] OFF_CTRL3 = 16'h0183;
   localparam logic [15:0] OFF_IO = 16'h0184;
   localparam logic [15:0] OFF_ES = 16'h0185;
   localparam logic [15:0] OFF_PAT = 16'h0186;
   localparam logic [15:0] OFF_HDLC = 16'h0187;
   localparam logic [15:0] OFF_IBO = 16'h0188;
   localparam logic [15:0] OFF_MON = 16'h0189;
   localparam logic [15:0] OFF_XP = 16'h018a;
   localparam logic [15:0] OFF_STAT = 16'h01c0;
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] MASK_CTRL3 = 8'h01;
   localparam logic [7:0] MASK_IO = 8'hff;
   localparam logic [7:0] MASK_ES = 8'hdf;
   localparam logic [7:0] MASK_PAT = 8'hff;
   localparam logic [7:0] MASK_HDLC = 8'h03;
   localparam logic [7:0] MASK_IBO = 8'h18;
   localparam logic [7:0] MASK_MON = 8'h1f;
   localparam logic [7:0] MASK_XP = 8'h07;
   localparam int unsigned B_CRC_RECALC = 0;
   localparam int unsigned B_CLK_INV = 7;
   localparam int unsigned B_LSYNC_INV = 6;
   localparam int unsigned B_SSYNC_INV = 5;
   localparam int unsigned B_RATE_SEL = 4;
   localparam int unsigned B_SSYNC_MF = 3;
   localparam int unsigned B_LSYNC_DIR = 2;
   localparam int unsigned B_DBL_WIDE = 1;
   localparam int unsigned B_LSYNC_MF = 0;
   localparam int unsigned B_DATA_FMT = 7;
   localparam int unsigned B_GAP_CLK = 6;
   localparam int unsigned B_SLIP_ZONE = 4;
   localparam int unsigned B_ALIGN = 3;
   localparam int unsigned B_RECENTER = 2;
   localparam int unsigned B_MIN_DELAY = 1;
   localparam int unsigned B_ES_EN = 0;
   localparam int unsigned B_MW_LAW = 7;
   localparam int unsigned B_INV_LO = 5;
   localparam int unsigned B_JAM8 = 4;
   localparam int unsigned B_RAI_CI = 3;
   localparam int unsigned B_AIS_CI = 2;
   localparam int unsigned B_LOOP_LO = 0;
   localparam int unsigned B_WM_LO = 0;
   localparam int unsigned B_IBO_TYPE = 4;
   localparam int unsigned B_IBO_EN = 3;
   localparam int unsigned B_BERT_DIR = 2;
   localparam int unsigned B_BERT_UNF = 1;
   localparam int unsigned B_BERT_EN = 0;
   localparam logic [3:0] SLIP_WIDE = 4'h9;
   localparam logic [3:0] SLIP_NARROW = 4'h2;
   localparam logic [5:0] WM_00 = 6'h04;
   localparam logic [5:0] WM_01 = 6'h10;
   localparam logic [5:0] WM_10 = 6'h20;
   localparam logic [5:0] WM_11 = 6'h30;
   localparam logic [4:0] LEN_00 = 5'h05;
   localparam logic [4:0] LEN_01 = 5'h06;
   localparam logic [4:0] LEN_10 = 5'h07;
   localparam logic [4:0] LEN_11 = 5'h10;
   localparam logic [7:0] MW_ULAW = 8'h1e;
   localparam logic [7:0] MW_ALAW = 8'h34;
   typedef enum logic [1:0] {
      INV_NONE = 2'b00,
      INV_FRAMING = 2'b01,
      INV_SIGNALING = 2'b10,
      INV_PAYLOAD = 2'b11
   } txcfg_inv_e;
endpackage

/* File: core/txcfg_port_if.sv */
// Per-port decoded write strobes and register values
`timescale 1ns/10ps
`default_nettype none
interface txcfg_port_if;
   logic [2:0] idx;
   logic wr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic hit;
   modport bank (input idx, input wr, input wdata, output rdata,
      output hit);
   modport ctrl (output idx, output wr, output wdata, input rdata,
      input hit);
endinterface
`default_nettype wire

/* File: core/txcfg_port_bank.sv */
// One port's register bank with elastic store command edges
`timescale 1ns/10ps
`default_nettype none
module txcfg_port_bank (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Register access
   txcfg_port_if.bank rif,
   // Stored values
   output logic [7:0] regs_o [0:7],
   // Elastic store commands
   output logic align_pulse_o,
   output logic recenter_pulse_o
);
   logic [7:0] regs_q [0:7];
   logic [7:0] mask [0:7];
   assign mask[0] = txcfg_pkg::MASK_CTRL3;
   assign mask[1] = txcfg_pkg::MASK_IO;
   assign mask[2] = txcfg_pkg::MASK_ES;
   assign mask[3] = txcfg_pkg::MASK_PAT;
   assign mask[4] = txcfg_pkg::MASK_HDLC;
   assign mask[5] = txcfg_pkg::MASK_IBO;
   assign mask[6] = txcfg_pkg::MASK_MON;
   assign mask[7] = txcfg_pkg::MASK_XP;
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_reg
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               regs_q[g] <= txcfg_pkg::RST_REG;
            end else if (rif.wr && rif.idx == 3'(g)) begin
               regs_q[g] <= rif.wdata & mask[g];
            end
         end
         assign regs_o[g] = regs_q[g];
      end
   endgenerate
   assign rif.rdata = regs_q[rif.idx];
   assign rif.hit = 1'b1;
   // Rising edges of align and recenter
   logic es_wr;
   assign es_wr = rif.wr && rif.idx == 3'd2;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         align_pulse_o <= 1'b0;
         recenter_pulse_o <= 1'b0;
      end else begin
         align_pulse_o <= es_wr && rif.wdata[txcfg_pkg::B_ALIGN] &&
            !regs_q[2][txcfg_pkg::B_ALIGN];
         recenter_pulse_o <= es_wr && rif.wdata[txcfg_pkg::B_RECENTER] &&
            !regs_q[2][txcfg_pkg::B_RECENTER];
      end
   end
endmodule
`default_nettype wire

/* File: core/txcfg_bank.sv */
// Transmit port configuration bank, sixteen ports behind APB
`timescale 1ns/10ps
`default_nettype none
module txcfg_bank #(
   parameter int unsigned PORTS = txcfg_pkg::NUM_PORTS,
   parameter int unsigned FRAME_BYTES = 32
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Mode inputs
   input wire logic [15:0] e1_mode,
   input wire logic [15:0] rate_conv,
   // Raw pins per port
   input wire logic [15:0] tx_line_clock_pin,
   input wire logic [15:0] tx_line_sync_in,
   input wire logic [15:0] tx_line_sync_gen,
   input wire logic [15:0] tx_system_sync_pin,
   // Conditioned pins per port
   output logic [15:0] line_clock_int,
   output logic [15:0] line_sync_int,
   output logic [15:0] system_sync_int,
   output logic [15:0] tx_line_sync_out,
   output logic [15:0] tx_line_sync_oe,
   // Decoded controls per port
   output logic [15:0] crc_recalc,
   output logic [15:0] system_clock_rate_sel,
   output logic [15:0] system_sync_mf_sel,
   output logic [15:0] line_sync_mf_sel,
   output logic [15:0] sync_double_wide,
   output logic [15:0] channel_data_format,
   output logic [15:0] gapped_clock_enable,
   output logic [15:0] estore_enable,
   output logic [15:0] estore_min_delay,
   output logic [15:0] estore_align_cmd,
   output logic [15:0] estore_recenter_cmd,
   output logic [63:0] slip_threshold,
   output logic [127:0] milliwatt_code,
   output logic [31:0] bit_invert_select,
   output logic [15:0] jammed_bit8_enable,
   output logic [15:0] remote_alarm_ci_mode,
   output logic [15:0] ais_ci_mode,
   output logic [79:0] loop_code_length,
   output logic [95:0] fifo_low_watermark,
   output logic [15:0] interleave_enable,
   output logic [15:0] interleave_type,
   output logic [79:0] monitor_channel_select,
   output logic [15:0] bert_port_enable,
   output logic [15:0] bert_port_direction,
   output logic [15:0] bert_unframed
);
   // Address decode: port index and register index
   // Offsets are word indices, byte address is four times that
   logic [15:0] word_a;
   logic [15:0] rel;
   logic [3:0] port_n;
   logic [3:0] blk_n;
   logic [8:0] low;
   logic addr_ok;
   assign word_a = {2'b00, paddr[15:2]};
   always_comb begin
      rel = word_a;
      port_n = 4'h0;
      blk_n = 4'h0;
      if (word_a >= txcfg_pkg::HALF_STRIDE) begin
         rel = word_a - txcfg_pkg::HALF_STRIDE;
         port_n = 4'(txcfg_pkg::PORTS_PER_HALF);
         // Upper ports sit one stride block higher
         blk_n = 4'h1;
      end
      port_n = port_n + 4'(rel[11:9]);
      low = rel[8:0];
      addr_ok = (paddr[1:0] == 2'b00) && (rel[15:12] == blk_n) &&
         (low >= txcfg_pkg::OFF_CTRL3[8:0]) &&
         (low <= txcfg_pkg::OFF_XP[8:0]) &&
         (32'(port_n) < PORTS);
   end
   logic stat_hit;
   assign stat_hit = (paddr[1:0] == 2'b00) &&
      (word_a == txcfg_pkg::OFF_STAT);
   logic [2:0] reg_idx;
   assign reg_idx = 3'(low - txcfg_pkg::OFF_CTRL3[8:0]);
   logic access;
   assign access = psel && penable && !pready;
   // Per-port banks
   logic [7:0] rd_mux [0:15];
   logic [7:0] regs [0:15][0:7];
   logic [15:0] al_p, rc_p;
   genvar p;
   generate
      for (p = 0; p < 16; p++) begin : g_port
         txcfg_port_if pif ();
         assign pif.idx = reg_idx;
         assign pif.wdata = pwdata[7:0];
         // Write lands at the edge that completes the access
         assign pif.wr = psel && penable && pready && pwrite && addr_ok &&
            port_n == 4'(p) && 32'(p) < PORTS;
         assign rd_mux[p] = pif.rdata;
         txcfg_port_bank u_bank (
            .pclk(pclk),
            .presetn(presetn),
            .rif(pif),
            .regs_o(regs[p]),
            .align_pulse_o(al_p[p]),
            .recenter_pulse_o(rc_p[p])
         );
         // Decoded outputs, all registered
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               line_clock_int[p] <= 1'b0;
               line_sync_int[p] <= 1'b0;
               system_sync_int[p] <= 1'b0;
               tx_line_sync_out[p] <= 1'b0;
               tx_line_sync_oe[p] <= 1'b0;
               crc_recalc[p] <= 1'b0;
               system_clock_rate_sel[p] <= 1'b0;
               system_sync_mf_sel[p] <= 1'b0;
               line_sync_mf_sel[p] <= 1'b0;
               sync_double_wide[p] <= 1'b0;
               channel_data_format[p] <= 1'b0;
               gapped_clock_enable[p] <= 1'b0;
               estore_enable[p] <= 1'b0;
               estore_min_delay[p] <= 1'b0;
               estore_align_cmd[p] <= 1'b0;
               estore_recenter_cmd[p] <= 1'b0;
               slip_threshold[p*4 +: 4] <= 4'h0;
               milliwatt_code[p*8 +: 8] <= 8'h00;
               bit_invert_select[p*2 +: 2] <= 2'b00;
               jammed_bit8_enable[p] <= 1'b0;
               remote_alarm_ci_mode[p] <= 1'b0;
               ais_ci_mode[p] <= 1'b0;
               loop_code_length[p*5 +: 5] <= 5'h00;
               fifo_low_watermark[p*6 +: 6] <= 6'h00;
               interleave_enable[p] <= 1'b0;
               interleave_type[p] <= 1'b0;
               monitor_channel_select[p*5 +: 5] <= 5'h00;
               bert_port_enable[p] <= 1'b0;
               bert_port_direction[p] <= 1'b0;
               bert_unframed[p] <= 1'b0;
            end else begin
               line_clock_int[p] <= tx_line_clock_pin[p] ^
                  regs[p][1][txcfg_pkg::B_CLK_INV];
               line_sync_int[p] <= tx_line_sync_in[p] ^
                  regs[p][1][txcfg_pkg::B_LSYNC_INV];
               system_sync_int[p] <= tx_system_sync_pin[p] ^
                  regs[p][1][txcfg_pkg::B_SSYNC_INV];
               tx_line_sync_out[p] <= tx_line_sync_gen[p] ^
                  regs[p][1][txcfg_pkg::B_LSYNC_INV];
               tx_line_sync_oe[p] <=
                  regs[p][1][txcfg_pkg::B_LSYNC_DIR];
               crc_recalc[p] <= e1_mode[p] &&
                  regs[p][0][txcfg_pkg::B_CRC_RECALC];
               system_clock_rate_sel[p] <=
                  regs[p][1][txcfg_pkg::B_RATE_SEL];
               system_sync_mf_sel[p] <=
                  regs[p][1][txcfg_pkg::B_SSYNC_MF];
               line_sync_mf_sel[p] <=
                  regs[p][1][txcfg_pkg::B_LSYNC_MF];
               sync_double_wide[p] <= !e1_mode[p] &&
                  regs[p][1][txcfg_pkg::B_DBL_WIDE];
               channel_data_format[p] <=
                  regs[p][2][txcfg_pkg::B_DATA_FMT];
               gapped_clock_enable[p] <=
                  regs[p][2][txcfg_pkg::B_GAP_CLK];
               estore_enable[p] <=
                  regs[p][2][txcfg_pkg::B_ES_EN];
               estore_min_delay[p] <=
                  regs[p][2][txcfg_pkg::B_MIN_DELAY];
               estore_align_cmd[p] <= al_p[p];
               estore_recenter_cmd[p] <= rc_p[p];
               if (!rate_conv[p]) begin
                  slip_threshold[p*4 +: 4] <= 4'h0;
               end else if (regs[p][2][txcfg_pkg::B_SLIP_ZONE]) begin
                  slip_threshold[p*4 +: 4] <=
                     txcfg_pkg::SLIP_NARROW;
               end else begin
                  slip_threshold[p*4 +: 4] <=
                     txcfg_pkg::SLIP_WIDE;
               end
               milliwatt_code[p*8 +: 8] <=
                  regs[p][3][txcfg_pkg::B_MW_LAW] ?
                  txcfg_pkg::MW_ALAW : txcfg_pkg::MW_ULAW;
               bit_invert_select[p*2 +: 2] <=
                  regs[p][3][txcfg_pkg::B_INV_LO +: 2];
               jammed_bit8_enable[p] <=
                  regs[p][3][txcfg_pkg::B_JAM8];
               remote_alarm_ci_mode[p] <= !e1_mode[p] &&
                  regs[p][3][txcfg_pkg::B_RAI_CI];
               ais_ci_mode[p] <= !e1_mode[p] &&
                  regs[p][3][txcfg_pkg::B_AIS_CI];
               case (regs[p][3][txcfg_pkg::B_LOOP_LO +: 2])
                  2'b00: loop_code_length[p*5 +: 5] <=
                     txcfg_pkg::LEN_00;
                  2'b01: loop_code_length[p*5 +: 5] <= txcfg_pkg::LEN_01;
                  2'b10: loop_code_length[p*5 +: 5] <= txcfg_pkg::LEN_10;
                  default: loop_code_length[p*5 +: 5] <=
                     txcfg_pkg::LEN_11;
               endcase
               case (regs[p][4][txcfg_pkg::B_WM_LO +: 2])
                  2'b00: fifo_low_watermark[p*6 +: 6] <=
                     txcfg_pkg::WM_00;
                  2'b01: fifo_low_watermark[p*6 +: 6] <= txcfg_pkg::WM_01;
                  2'b10: fifo_low_watermark[p*6 +: 6] <= txcfg_pkg::WM_10;
                  default: fifo_low_watermark[p*6 +: 6] <=
                     txcfg_pkg::WM_11;
               endcase
               interleave_enable[p] <=
                  regs[p][5][txcfg_pkg::B_IBO_EN];
               interleave_type[p] <=
                  regs[p][5][txcfg_pkg::B_IBO_TYPE];
               monitor_channel_select[p*5 +: 5] <=
                  regs[p][6][4:0];
               bert_port_enable[p] <=
                  regs[p][7][txcfg_pkg::B_BERT_EN];
               bert_port_direction[p] <=
                  regs[p][7][txcfg_pkg::B_BERT_DIR];
               bert_unframed[p] <=
                  regs[p][7][txcfg_pkg::B_BERT_UNF];
            end
         end
      end
   endgenerate
   // Status word: inconsistent double wide setting per port
   logic [15:0] dw_bad;
   generate
      for (p = 0; p < 16; p++) begin : g_chk
         assign dw_bad[p] = regs[p][1][txcfg_pkg::B_DBL_WIDE] &&
            (regs[p][1][txcfg_pkg::B_LSYNC_MF] ||
            !regs[p][1][txcfg_pkg::B_LSYNC_DIR]);
      end
   endgenerate
   // APB answer, one wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= access;
         pslverr <= access && !addr_ok && !(stat_hit && !pwrite);
         prdata <= 32'h0000_0000;
         if (access && !pwrite && addr_ok) begin
            prdata <= {24'h00_0000, rd_mux[port_n]};
         end else if (access && !pwrite && stat_hit) begin
            prdata <= {16'h0000, dw_bad};
         end
      end
   end
endmodule
`default_nettype wire

/* File: verification/txcfg_bank_asserts.sv */
// Bus and decode checks for the transmit port configuration bank
`timescale 1ns/10ps
`default_nettype none
module txcfg_bank_asserts (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Mode and decoded controls
   input wire logic [15:0] e1_mode,
   input wire logic [15:0] crc_recalc,
   input wire logic [15:0] sync_double_wide,
   input wire logic [15:0] ais_ci_mode,
   input wire logic [15:0] remote_alarm_ci_mode,
   input wire logic [15:0] estore_align_cmd,
   input wire logic [63:0] slip_threshold,
   input wire logic [95:0] fifo_low_watermark
);
   localparam int P = 9;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_one_wait: assert property (
      psel && penable && !pready |=> pready)
      else $error("pready not one cycle after access taken");
   a_ready_in_access: assert property (
      !(psel && penable) |-> !pready)
      else $error("pready outside an access");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata nonzero outside answer");
   a_rdata_upper: assert property (
      pready |-> prdata[31:16] == 16'h0)
      else $error("prdata upper bits set");
   a_crc_t1_off: assert property (
      !e1_mode[P] && !$past(e1_mode[P]) |-> !crc_recalc[P])
      else $error("crc recalc active in T1");
   a_wide_e1_off: assert property (
      e1_mode[P] && $past(e1_mode[P]) |-> !sync_double_wide[P])
      else $error("double wide active in E1");
   a_ci_e1_off: assert property (
      e1_mode[P] && $past(e1_mode[P])
      |-> !ais_ci_mode[P] && !remote_alarm_ci_mode[P])
      else $error("alarm CI mode active in E1");
   a_align_pulse: assert property (
      estore_align_cmd[P] |=> !estore_align_cmd[P])
      else $error("align command not a pulse");
   a_slip_legal: assert property (
      slip_threshold[4*P+:4] inside {4'h0, 4'h9, 4'h2})
      else $error("slip threshold illegal");
   a_wm_legal: assert property (
      $past(presetn) |-> fifo_low_watermark[6*P+:6] inside
      {6'h04, 6'h10, 6'h20, 6'h30})
      else $error("watermark illegal");
   c_refused: cover property (pready && pslverr);
   c_done: cover property (pready && !pslverr);
   c_align: cover property (estore_align_cmd[P]);
endmodule
bind txcfg_bank txcfg_bank_asserts chk_u (.pclk, .presetn, .psel, .penable,
   .prdata, .pready, .pslverr, .e1_mode, .crc_recalc, .sync_double_wide,
   .ais_ci_mode, .remote_alarm_ci_mode, .estore_align_cmd, .slip_threshold,
   .fifo_low_watermark);
`default_nettype wire

/* File: verification/test_txcfg_bank.sv */
// Self-checking bench for the transmit port configuration bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
$display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_txcfg_bank;
   localparam int PI = 9;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [15:0] paddr = 16'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic [15:0] e1_mode = 16'h0, rate_conv = 16'h0, tx_line_clock_pin = 16'h0;
   logic [15:0] tx_line_sync_in = 16'h0, tx_line_sync_gen = 16'h0;
   logic [15:0] tx_system_sync_pin = 16'h0;
   logic [15:0] line_clock_int, line_sync_int, system_sync_int;
   logic [15:0] tx_line_sync_out, tx_line_sync_oe, crc_recalc;
   logic [15:0] system_clock_rate_sel, system_sync_mf_sel, line_sync_mf_sel;
   logic [15:0] sync_double_wide, channel_data_format, gapped_clock_enable;
   logic [15:0] estore_enable, estore_min_delay, estore_align_cmd;
   logic [15:0] estore_recenter_cmd, jammed_bit8_enable, remote_alarm_ci_mode;
   logic [15:0] ais_ci_mode, interleave_enable, interleave_type;
   logic [15:0] bert_port_enable, bert_port_direction, bert_unframed;
   logic [63:0] slip_threshold;
   logic [127:0] milliwatt_code;
   logic [31:0] bit_invert_select;
   logic [79:0] loop_code_length, monitor_channel_select;
   logic [95:0] fifo_low_watermark;
   int err_count = 0, n_checks = 0, cyc = 0, n_al = 0, n_rc = 0;

   txcfg_bank dut_u (.*);

   always #4 pclk = ~pclk;

   // Elastic store command pulses and run limit
   always @(posedge pclk) begin
      if (estore_align_cmd[PI] === 1'b1) n_al++;
      if (estore_recenter_cmd[PI] === 1'b1) n_rc++;
      cyc++;
      if (cyc == 4000) begin
         err_count++;
         wrap_up();
      end
   end

   // Byte address is four times the word offset
   function automatic logic [15:0] ad(input int p, input logic [15:0] o);
      return (o + 16'(p) * txcfg_pkg::PORT_STRIDE +
         16'(p / 8) * txcfg_pkg::HALF_STRIDE) << 2;
   endfunction

   function automatic logic [7:0] iov();
      return {line_clock_int[PI], line_sync_int[PI], system_sync_int[PI],
         tx_line_sync_oe[PI], system_clock_rate_sel[PI],
         system_sync_mf_sel[PI], line_sync_mf_sel[PI], sync_double_wide[PI]};
   endfunction

   task automatic wrap_up();
      $display("Checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
         input logic [7:0] x, input logic ee);
      logic [31:0] r;
      logic e;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      `CHK({e, r & {32{!w}}}, {ee, 24'h0, x & {8{!w}}})
   endtask

   task automatic wr(input int p, input logic [15:0] o, input logic [7:0] d);
      acc(1'b1, ad(p, o), d, 8'h00, 1'b0);
      repeat (2) @(posedge pclk);
      @(negedge pclk);
   endtask

   initial begin
      logic [7:0] msk [8];
      logic [4:0] lt [4];
      logic [5:0] wt [4];
      logic [15:0] ra;
      logic [7:0] pat;
      logic [7:0] mw;
      msk = '{txcfg_pkg::MASK_CTRL3, txcfg_pkg::MASK_IO, txcfg_pkg::MASK_ES,
         txcfg_pkg::MASK_PAT, txcfg_pkg::MASK_HDLC, txcfg_pkg::MASK_IBO,
         txcfg_pkg::MASK_MON, txcfg_pkg::MASK_XP};
      lt = '{5'd5, 5'd6, 5'd7, 5'd16};
      wt = '{6'd4, 6'd16, 6'd32, 6'd48};
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int p = 0; p < 16; p += 7) begin
         for (int i = 0; i < 8; i++) begin
            ra = ad(p, txcfg_pkg::OFF_CTRL3 + 16'(i));
            acc(0, ra, 0, 0, 0);
            acc(1, ra, 8'hff, 0, 0);
            acc(0, ra, 0, msk[i], 0);
            acc(1, ra, 0, 0, 0);
         end
         acc(0, ad(p, 16'h018b), 0, 0, 1);
         acc(1, ad(p, txcfg_pkg::OFF_STAT), 8'h01, 0, 1);
      end
      acc(0, ad(0, txcfg_pkg::OFF_IO) + 16'h0001, 0, 0, 1);
      wr(PI, txcfg_pkg::OFF_IO, 8'h9d);
      `CHK(iov(), 8'h9e)
      @(posedge pclk);
      tx_line_clock_pin[PI] <= 1'b1;
      wr(PI, txcfg_pkg::OFF_IO, 8'h66);
      `CHK(iov(), 8'hf1)
      `CHK(tx_line_sync_out[PI], 1'b1)
      acc(0, ad(0, txcfg_pkg::OFF_STAT), 0, 0, 0);
      for (int v = 0; v < 4; v++) begin
         pat = {v[0], v[1:0], 3'b111, v[1:0]};
         mw = v[0] ? txcfg_pkg::MW_ALAW : txcfg_pkg::MW_ULAW;
         wr(PI, txcfg_pkg::OFF_PAT, pat);
         wr(PI, txcfg_pkg::OFF_HDLC, {6'h0, v[1:0]});
         `CHK(milliwatt_code[8*PI+:8], mw)
         `CHK(bit_invert_select[2*PI+:2], v[1:0])
         `CHK(loop_code_length[5*PI+:5], lt[v])
         `CHK(jammed_bit8_enable[PI], 1'b1)
         `CHK(remote_alarm_ci_mode[PI], 1'b1)
         `CHK(ais_ci_mode[PI], 1'b1)
         `CHK(fifo_low_watermark[6*PI+:6], wt[v])
      end
      wr(PI, txcfg_pkg::OFF_CTRL3, 8'h01);
      `CHK({crc_recalc[PI], sync_double_wide[PI]}, 2'b01)
      @(posedge pclk);
      e1_mode[PI] <= 1'b1;
      rate_conv[PI] <= 1'b1;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      `CHK({crc_recalc[PI], sync_double_wide[PI]}, 2'b10)
      `CHK({remote_alarm_ci_mode[PI], ais_ci_mode[PI]}, 2'b00)
      wr(PI, txcfg_pkg::OFF_ES, 8'hd9);
      wr(PI, txcfg_pkg::OFF_ES, 8'hd9);
      `CHK(channel_data_format[PI], 1'b1)
      `CHK(gapped_clock_enable[PI], 1'b1)
      `CHK({estore_enable[PI], estore_min_delay[PI]}, 2'b10)
      `CHK(slip_threshold[4*PI+:4], txcfg_pkg::SLIP_NARROW)
      `CHK(n_al, 1)
      wr(PI, txcfg_pkg::OFF_ES, 8'h06);
      `CHK({estore_enable[PI], estore_min_delay[PI]}, 2'b01)
      `CHK(slip_threshold[4*PI+:4], txcfg_pkg::SLIP_WIDE)
      `CHK(n_rc, 1)
      wr(PI, txcfg_pkg::OFF_ES, 8'h02);
      wr(PI, txcfg_pkg::OFF_ES, 8'h06);
      `CHK(n_rc, 2)
      wr(PI, txcfg_pkg::OFF_ES, 8'h02);
      `CHK(n_rc, 2)
      @(posedge pclk);
      rate_conv[PI] <= 1'b0;
      repeat (2) @(posedge pclk);
      @(negedge pclk);
      `CHK(slip_threshold[4*PI+:4], 4'h0)
      wr(PI, txcfg_pkg::OFF_IBO, 8'h18);
      `CHK({interleave_enable[PI], interleave_type[PI]}, 2'b11)
      wr(PI, txcfg_pkg::OFF_IBO, 8'h08);
      `CHK({interleave_enable[PI], interleave_type[PI]}, 2'b10)
      for (int m = 31; m >= 0; m -= 31) begin
         wr(PI, txcfg_pkg::OFF_MON, 8'(m));
         `CHK(monitor_channel_select[5*PI+:5], 5'(m))
      end
      for (int v = 0; v < 8; v++) begin
         wr(PI, txcfg_pkg::OFF_XP, 8'(v));
         `CHK(bert_port_direction[PI], v[2])
         `CHK(bert_unframed[PI], v[1])
         `CHK(bert_port_enable[PI], v[0])
      end
      wrap_up();
   end
endmodule
`default_nettype wire
